// ---- fprmc_model_dec.sv ----
// Package of shared constants and the computation model decoder.
package fprmc_pkg;
    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register offsets.
    localparam logic [3:0] OFF_TRAPS  = 4'h0;
    localparam logic [3:0] OFF_SF0    = 4'h1;
    localparam logic [3:0] OFF_SF1    = 4'h2;
    localparam logic [3:0] OFF_SF2    = 4'h3;
    localparam logic [3:0] OFF_SF3    = 4'h4;
    localparam logic [3:0] OFF_IRQ_ST = 4'h5;
    localparam logic [3:0] OFF_IRQ_MK = 4'h6;
    // Status field layout.
    localparam int SF_W     = 13;
    localparam int NUM_SF   = 4;
    localparam int FTZ_BIT  = 0;
    localparam int WRE_BIT  = 1;
    localparam int PC_LO    = 2;
    localparam int RC_LO    = 4;
    localparam int TD_BIT   = 6;
    localparam int FLAG_LO  = 7;
    // Exception order shared by trap bits and flags.
    localparam int NUM_EXC  = 6;
    localparam int EXC_V    = 0;
    localparam int EXC_D    = 1;
    localparam int EXC_Z    = 2;
    localparam int EXC_O    = 3;
    localparam int EXC_U    = 4;
    localparam int EXC_I    = 5;
    // Interrupt status bits.
    localparam int IRQ_W    = 2;
    localparam int IRQ_TRAP = 0;
    localparam int IRQ_RSV  = 1;
    // Reset values.
    localparam logic [NUM_EXC-1:0] TRAPS_RST = 6'h3f;
    localparam logic [SF_W-1:0]    SF_RST    = 13'h0000;
    // Model widths in bits.
    localparam logic [6:0] SIG_24 = 7'h18;
    localparam logic [6:0] SIG_53 = 7'h35;
    localparam logic [6:0] SIG_64 = 7'h40;
    localparam logic [4:0] EXP_8  = 5'h08;
    localparam logic [4:0] EXP_11 = 5'h0b;
    localparam logic [4:0] EXP_15 = 5'h0f;
    localparam logic [4:0] EXP_17 = 5'h11;
    // Precision completer carried by the instruction.
    typedef enum logic [1:0] {
        PCC_NONE = 2'b00,
        PCC_S    = 2'b01,
        PCC_D    = 2'b10
    } fprmc_pcc_e;
    // Dynamic precision control codes.
    localparam logic [1:0] PC_24  = 2'b00;
    localparam logic [1:0] PC_RSV = 2'b01;
    localparam logic [1:0] PC_53  = 2'b10;
    localparam logic [1:0] PC_64  = 2'b11;
    // Rounding directions.
    typedef enum logic [1:0] {
        RND_NEAR = 2'b00,
        RND_DOWN = 2'b01,
        RND_UP   = 2'b10,
        RND_ZERO = 2'b11
    } fprmc_rnd_e;
    // Instruction issue from decode.
    typedef struct packed {
        logic [1:0] sf_sel;
        fprmc_pcc_e pcc;
        logic       parallel;
    } fprmc_op_s;
    // Raw result facts from the datapath.
    typedef struct packed {
        logic               tiny;
        logic               sign;
        logic [NUM_EXC-1:0] exc;
    } fprmc_res_s;
    // Control answer back to the datapath.
    typedef struct packed {
        logic               valid;
        fprmc_rnd_e         rnd;
        logic [6:0]         sig_bits;
        logic [4:0]         exp_bits;
        logic               reserved;
        logic               flush;
        logic               flush_sign;
        logic [NUM_EXC-1:0] trap;
    } fprmc_ctl_s;
endpackage

`timescale 1ns/1ps

// Picks significand and exponent widths from completer and field controls.
module fprmc_model_dec (
    input  wire fprmc_pkg::fprmc_pcc_e pcc_i,
    input  wire logic                  parallel_i,
    input  wire logic                  wre_i,
    input  wire logic [1:0]            pc_i,
    output logic [6:0]                 sig_bits_o,
    output logic [4:0]                 exp_bits_o,
    output logic                       reserved_o
);
    import fprmc_pkg::*;

    // Pure decode; the caller registers the result.
    always_comb begin
        reserved_o = 1'b0;
        sig_bits_o = SIG_64;
        exp_bits_o = EXP_17;
        if (pcc_i == PCC_S || pcc_i == PCC_D) begin
            // Static completer wins over the dynamic precision.
            sig_bits_o = (pcc_i == PCC_S) ? SIG_24 : SIG_53;
            if (wre_i) begin
                exp_bits_o = EXP_17;
            end else begin
                exp_bits_o = (pcc_i == PCC_S) ? EXP_8 : EXP_11;
            end
        end else if (parallel_i) begin
            // Paired single lanes ignore the dynamic precision and range controls.
            sig_bits_o = SIG_24;
            exp_bits_o = EXP_8;
        end else if (pcc_i == PCC_NONE) begin
            // Dynamic precision selects the width.
            exp_bits_o = wre_i ? EXP_17 : EXP_15;
            case (pc_i)
                PC_24:   sig_bits_o = SIG_24;
                PC_53:   sig_bits_o = SIG_53;
                PC_64:   sig_bits_o = SIG_64;
                default: begin
                    // Reserved code: flagged, widest significand kept as fallback.
                    sig_bits_o = SIG_64;
                    reserved_o = 1'b1;
                end
            endcase
        end
    end
endmodule // fprmc_model_dec

// ---- fprmc_top.sv ----
// Result model control beside the floating-point datapath.
`timescale 1ns/1ps

module fprmc_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic [fprmc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [fprmc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    input  wire logic                    op_valid_i,
    input  wire fprmc_pkg::fprmc_op_s    op_i,
    input  wire fprmc_pkg::fprmc_res_s   res_i,
    output logic [fprmc_pkg::DATA_W-1:0] rdata_o,
    output fprmc_pkg::fprmc_ctl_s        ctl_o,
    output logic                         irq_o
);
    import fprmc_pkg::*;

    // Every flip-flop of the block lives in this one struct.
    typedef struct packed {
        logic [NUM_EXC-1:0]           traps;    // Shared trap disables.
        logic [NUM_SF-1:0][SF_W-1:0]  sf;       // Main plus alternates.
        logic [IRQ_W-1:0]             irq_st;   // Sticky event bits.
        logic [IRQ_W-1:0]             irq_mk;   // Interrupt mask.
        logic [DATA_W-1:0]            rdata;    // Read answer.
        fprmc_ctl_s                   ctl;      // Answer to datapath.
        logic                         irq;      // Interrupt line.
    } fprmc_state_s;

    fprmc_state_s st_ff;   // Registered state.
    fprmc_state_s nxt_st;  // Next state.

    logic [SF_W-1:0]    sel_sf;    // Field chosen by the current op.
    logic               td_eff;    // Field level trap override.
    logic [NUM_EXC-1:0] trap_en;   // Effective trap enables.
    logic               flush_c;   // Flush to zero taken this op.
    logic [NUM_EXC-1:0] trap_c;    // Exceptions signalled this op.
    logic [NUM_EXC-1:0] flag_set;  // Flags hardware sets this op.
    logic [6:0]         sig_c;     // Decoded significand width.
    logic [4:0]         exp_c;     // Decoded exponent width.
    logic               rsv_c;     // Reserved precision selected.

    // Width decode for the chosen field.
    fprmc_model_dec u_dec (
        .pcc_i      (op_i.pcc),
        .parallel_i (op_i.parallel),
        .wre_i      (sel_sf[WRE_BIT]),
        .pc_i       (sel_sf[PC_LO +: 2]),
        .sig_bits_o (sig_c),
        .exp_bits_o (exp_c),
        .reserved_o (rsv_c)
    );

    // Exception policy for the op in flight.
    always_comb begin
        sel_sf = st_ff.sf[op_i.sf_sel];
        // The main field has no override; its stored bit is held at zero.
        td_eff = (op_i.sf_sel != 2'b00) && sel_sf[TD_BIT];
        // A set trap bit disables; the override disables all six.
        trap_en = td_eff ? '0 : ~st_ff.traps;
        // Underflow enabled takes priority over flush mode.
        flush_c = op_valid_i && res_i.tiny && sel_sf[FTZ_BIT]
                  && !trap_en[EXC_U];
        trap_c = res_i.exc & trap_en;
        if (op_valid_i && res_i.tiny && trap_en[EXC_U]) begin
            trap_c[EXC_U] = 1'b1;
        end
        if (flush_c) begin
            // A flushed zero is always inexact, never a raised underflow.
            trap_c[EXC_U] = 1'b0;
            trap_c[EXC_I] = trap_en[EXC_I];
        end
        if (!op_valid_i) begin
            trap_c = '0;
        end
        flag_set = op_valid_i ? res_i.exc : '0;
        if (flush_c) begin
            flag_set[EXC_U] = 1'b1;
            flag_set[EXC_I] = 1'b1;
        end
    end

    // Next state: bus writes first, then hardware sets on top.
    always_comb begin
        nxt_st = st_ff;
        // Software writes to the register file.
        if (wr_i) begin
            case (addr_i)
                OFF_TRAPS: nxt_st.traps = wdata_i[NUM_EXC-1:0];
                OFF_SF0: begin
                    nxt_st.sf[0] = wdata_i[SF_W-1:0];
                    nxt_st.sf[0][TD_BIT] = 1'b0;
                end
                OFF_SF1:    nxt_st.sf[1] = wdata_i[SF_W-1:0];
                OFF_SF2:    nxt_st.sf[2] = wdata_i[SF_W-1:0];
                OFF_SF3:    nxt_st.sf[3] = wdata_i[SF_W-1:0];
                OFF_IRQ_ST: nxt_st.irq_st = st_ff.irq_st
                                            & ~wdata_i[IRQ_W-1:0];
                OFF_IRQ_MK: nxt_st.irq_mk = wdata_i[IRQ_W-1:0];
                default: begin
                    // Unmapped writes are dropped.
                end
            endcase
        end
        // Hardware only ever sets flags, so a same cycle clear loses.
        nxt_st.sf[op_i.sf_sel][FLAG_LO +: NUM_EXC] =
            nxt_st.sf[op_i.sf_sel][FLAG_LO +: NUM_EXC] | flag_set;
        if (|trap_c) begin
            nxt_st.irq_st[IRQ_TRAP] = 1'b1;
        end
        if (op_valid_i && rsv_c) begin
            nxt_st.irq_st[IRQ_RSV] = 1'b1;
        end
        // Read answer stands only in the cycle after the strobe.
        nxt_st.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                OFF_TRAPS:  nxt_st.rdata = {{(DATA_W-NUM_EXC){1'b0}},
                                            st_ff.traps};
                OFF_SF0: begin
                    nxt_st.rdata = {{(DATA_W-SF_W){1'b0}}, st_ff.sf[0]};
                    nxt_st.rdata[TD_BIT] = 1'b0;
                end
                OFF_SF1:    nxt_st.rdata = {{(DATA_W-SF_W){1'b0}},
                                            st_ff.sf[1]};
                OFF_SF2:    nxt_st.rdata = {{(DATA_W-SF_W){1'b0}},
                                            st_ff.sf[2]};
                OFF_SF3:    nxt_st.rdata = {{(DATA_W-SF_W){1'b0}},
                                            st_ff.sf[3]};
                OFF_IRQ_ST: nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}},
                                            st_ff.irq_st};
                OFF_IRQ_MK: nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}},
                                            st_ff.irq_mk};
                default:    nxt_st.rdata = '0;
            endcase
        end
        // Per-op answer to the datapath, standing only in the cycle after a valid op.
        nxt_st.ctl = '0;
        if (op_valid_i) begin
            nxt_st.ctl.valid = 1'b1;
            // Direction comes straight from the chosen field.
            nxt_st.ctl.rnd = fprmc_rnd_e'(sel_sf[RC_LO +: 2]);
            nxt_st.ctl.sig_bits = sig_c;
            nxt_st.ctl.exp_bits = exp_c;
            nxt_st.ctl.reserved = rsv_c;
            nxt_st.ctl.flush = flush_c;
            nxt_st.ctl.flush_sign = res_i.sign;
            nxt_st.ctl.trap = trap_c;
        end
        // Level interrupt tracks the registered status and mask.
        nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mk);
    end

    // Single register stage; synchronous active low reset.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_ff        <= '0;
            st_ff.traps  <= TRAPS_RST;
            st_ff.sf     <= {NUM_SF{SF_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign ctl_o   = st_ff.ctl;
    assign irq_o   = st_ff.irq;

    // Checks on the behaviour above.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Issue of a tiny result under flush mode with underflow disabled.
    sequence s_ftz_issue;
        op_valid_i && res_i.tiny && sel_sf[FTZ_BIT] && !trap_en[EXC_U];
    endsequence

    chk_flush_taken: assert property (
        s_ftz_issue |=> ctl_o.flush && ctl_o.flush_sign == $past(res_i.sign))
        else $error("Tiny result was not flushed.");

    chk_uflow_prio: assert property (
        op_valid_i && res_i.tiny && trap_en[EXC_U]
        |=> !ctl_o.flush && ctl_o.trap[EXC_U])
        else $error("Enabled underflow did not win over flush.");

    chk_flush_flags: assert property (
        s_ftz_issue ##1 1'b1 |->
        st_ff.sf[$past(op_i.sf_sel)][FLAG_LO+EXC_U]
        && st_ff.sf[$past(op_i.sf_sel)][FLAG_LO+EXC_I])
        else $error("Flush did not set underflow and inexact flags.");

    chk_flush_inex: assert property (
        s_ftz_issue and trap_en[EXC_I] |=> ctl_o.trap[EXC_I])
        else $error("Inexact not signalled on flush.");

    chk_round_dir: assert property (
        op_valid_i |=> ctl_o.valid
        && ctl_o.rnd == $past(sel_sf[RC_LO +: 2]))
        else $error("Rounding direction differs from field.");

    chk_narrow_model: assert property (
        op_valid_i && op_i.pcc == PCC_S && !sel_sf[WRE_BIT]
        |=> ctl_o.sig_bits == SIG_24 && ctl_o.exp_bits == EXP_8)
        else $error("Single model widths wrong.");

    chk_wide_exp: assert property (
        op_valid_i && op_i.pcc == PCC_D && sel_sf[WRE_BIT]
        |=> ctl_o.sig_bits == SIG_53 && ctl_o.exp_bits == EXP_17)
        else $error("Widest range double model wrong.");

    chk_pair_single: assert property (
        op_valid_i && op_i.pcc == PCC_NONE && op_i.parallel
        |=> ctl_o.sig_bits == SIG_24 && ctl_o.exp_bits == EXP_8)
        else $error("Parallel lanes not single.");

    chk_td_override: assert property (
        op_valid_i && op_i.sf_sel != 2'b00 && sel_sf[TD_BIT]
        && !res_i.tiny |=> ctl_o.trap == '0)
        else $error("Trap raised while field traps disabled.");

    chk_td0_zero: assert property (
        rd_i && addr_i == OFF_SF0 |=> !rdata_o[TD_BIT])
        else $error("Main field trap disable read nonzero.");

    chk_flag_sticky: assert property (
        !$past(wr_i) |->
        (($past(st_ff.sf[1]) & ~st_ff.sf[1]) == '0))
        else $error("Flag fell without a software write.");
endmodule // fprmc_top

// ---- fprmc_dp_model.sv ----
// Behavioural model of the decode and datapath side that feeds the block.
`timescale 1ns/1ps

// Issues one op for each go pulse and scrambles its lines between ops.
module fprmc_dp_model (
    input  wire logic                  clk_i,
    input  wire logic                  go_i,
    input  wire fprmc_pkg::fprmc_op_s  op_cmd_i,
    input  wire fprmc_pkg::fprmc_res_s res_cmd_i,
    output logic                       op_valid_o,
    output fprmc_pkg::fprmc_op_s       op_o,
    output fprmc_pkg::fprmc_res_s      res_o
);
    import fprmc_pkg::*;

    // Start quiet so the block sees defined lines from time zero.
    initial begin
        op_valid_o = 1'b0;
        op_o = '0;
        res_o = '0;
    end

    // Between ops the lines carry the inverse of the last value, because
    // the datapath no longer holds them and the block must not trust them.
    always @(posedge clk_i) begin
        op_valid_o <= go_i;
        op_o <= go_i ? op_cmd_i : ~op_o;
        res_o <= go_i ? res_cmd_i : ~res_o;
    end
endmodule // fprmc_dp_model

// ---- fprmc_top_tb.sv ----
// Self-checking testbench for the result model control block.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("Error %s expected %h seen %h", nm, e, g); \
    n_mismatch++; end end

// Top of the bench: clock, reset, register tasks and one task a scenario.
module fprmc_top_tb;
    import fprmc_pkg::*;

    logic        clk_i = 1'b0;      // Core clock, 100 ns period.
    logic        rst_n_i = 1'b0;    // Synchronous reset, active low.
    logic [3:0]  addr_i = 4'h0;     // Register address.
    logic [15:0] wdata_i = 16'h0;   // Register write data.
    logic        wr_i = 1'b0;       // Write strobe.
    logic        rd_i = 1'b0;       // Read strobe.
    logic        go = 1'b0;         // Asks the model for one op.
    fprmc_op_s   op_cmd = '0;       // Op the model is to issue.
    fprmc_res_s  res_cmd = '0;      // Result facts the model is to issue.
    logic        op_valid;          // Issue strobe from the model.
    fprmc_op_s   op;                // Op lines from the model.
    fprmc_res_s  res;               // Result lines from the model.
    logic [15:0] rdata_o;           // Read data from the block.
    fprmc_ctl_s  ctl_o;             // Control answer from the block.
    logic        irq_o;             // Interrupt level from the block.
    int          n_mismatch = 0;    // Mismatches seen.
    int          num_checks = 0;    // Comparisons made.
    logic [15:0] q;                 // Last value read back.

    always #50 clk_i = ~clk_i;

    fprmc_top fprmc_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .op_valid_i(op_valid), .op_i(op), .res_i(res),
        .rdata_o(rdata_o), .ctl_o(ctl_o), .irq_o(irq_o));

    fprmc_dp_model fprmc_dp_model_inst (.clk_i(clk_i), .go_i(go),
        .op_cmd_i(op_cmd), .res_cmd_i(res_cmd), .op_valid_o(op_valid),
        .op_o(op), .res_o(res));

    // One-cycle write; the slave never stalls.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read; data is taken in the single cycle where it stands.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Issues one op through the model; the answer is one cycle after issue.
    task automatic do_op(input fprmc_op_s o, input fprmc_res_s r);
        @(posedge clk_i);
        go <= 1'b1;
        op_cmd <= o;
        res_cmd <= r;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        #1 `CHK("ctl valid", 1'b1, ctl_o.valid)
    endtask

    // Waits a few cycles for the registered interrupt to settle.
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        #1 `CHK("irq_o", e, irq_o)
    endtask

    // Reset values of the trap bits, a field, the idle read data and the interrupt line.
    task automatic t_reset();
        rd(OFF_TRAPS, q);
        `CHK("traps", 16'h003f, q)
        rd(OFF_SF0, q);
        `CHK("sf0", 16'h0000, q)
        @(posedge clk_i);
        #1 `CHK("rdata idle", 16'h0000, rdata_o)
        `CHK("irq idle", 1'b0, irq_o)
        $display("t_reset done");
    endtask

    // Every completer, lane mode, range bit and precision code in turn.
    // Rounding control follows the precision code so all four occur too.
    task automatic t_model();
        fprmc_pcc_e p;
        logic [6:0] es;
        logic [4:0] ee;
        for (int k = 0; k < 48; k++) begin
            p = fprmc_pcc_e'(k[5:4]);
            wr(OFF_SF1, {10'h000, k[1:0], k[1:0], k[2], 1'b0});
            if (p != PCC_NONE) begin
                es = (p == PCC_S) ? SIG_24 : SIG_53;
                ee = k[2] ? EXP_17 : ((p == PCC_S) ? EXP_8 : EXP_11);
            end else if (k[3]) begin
                es = SIG_24;
                ee = EXP_8;
            end else begin
                es = (k[1:0] == PC_24) ? SIG_24 :
                     (k[1:0] == PC_53) ? SIG_53 : SIG_64;
                ee = k[2] ? EXP_17 : EXP_15;
            end
            do_op('{2'd1, p, k[3]}, '{1'b0, 1'b0, 6'h00});
            `CHK("sig", es, ctl_o.sig_bits)
            `CHK("exp", ee, ctl_o.exp_bits)
            `CHK("rnd", k[1:0], ctl_o.rnd)
            `CHK("rsv", p == PCC_NONE && !k[3] && k[1:0] == PC_RSV,
                 ctl_o.reserved)
        end
        $display("t_model done");
    endtask

    // Tiny results flush to signed zero and set sticky flags in one field.
    task automatic t_flush();
        wr(OFF_TRAPS, 16'h003f);
        wr(OFF_SF2, 16'h0001);
        do_op('{2'd2, PCC_D, 1'b0}, '{1'b1, 1'b1, 6'h00});
        `CHK("flush", 1'b1, ctl_o.flush)
        `CHK("flush sign", 1'b1, ctl_o.flush_sign)
        `CHK("trap", 6'h00, ctl_o.trap)
        do_op('{2'd2, PCC_S, 1'b0}, '{1'b1, 1'b0, 6'h00});
        `CHK("flush sign pos", 1'b0, ctl_o.flush_sign)
        do_op('{2'd2, PCC_S, 1'b0}, '{1'b0, 1'b0, 6'h00});
        `CHK("no flush", 1'b0, ctl_o.flush)
        rd(OFF_SF2, q);
        `CHK("sf2 flags", 16'h1801, q)
        rd(OFF_SF3, q);
        `CHK("sf3 untouched", 16'h0000, q)
        wr(OFF_SF2, 16'h0001);
        rd(OFF_SF2, q);
        `CHK("sf2 cleared", 16'h0001, q)
        $display("t_flush done");
    endtask

    // Trap enables: underflow beats flushing, inexact on a flush, each
    // shared bit alone, and the per-field override.
    task automatic t_traps();
        wr(OFF_TRAPS, 16'h002f);
        do_op('{2'd2, PCC_D, 1'b0}, '{1'b1, 1'b0, 6'h00});
        `CHK("uf no flush", 1'b0, ctl_o.flush)
        `CHK("uf trap", 6'h10, ctl_o.trap)
        wr(OFF_TRAPS, 16'h001f);
        do_op('{2'd2, PCC_D, 1'b0}, '{1'b1, 1'b0, 6'h00});
        `CHK("ix flush", 1'b1, ctl_o.flush)
        `CHK("ix trap", 6'h20, ctl_o.trap)
        for (int i = 0; i < NUM_EXC; i++) begin
            wr(OFF_TRAPS, {10'h000, ~(6'h01 << i)});
            do_op('{2'd1, PCC_D, 1'b0}, '{1'b0, 1'b0, 6'h3f});
            `CHK("one trap", 6'h01 << i, ctl_o.trap)
        end
        wr(OFF_TRAPS, 16'h0000);
        wr(OFF_SF3, 16'h0040);
        do_op('{2'd3, PCC_D, 1'b0}, '{1'b0, 1'b0, 6'h3f});
        `CHK("td override", 6'h00, ctl_o.trap)
        wr(OFF_SF0, 16'h0040);
        rd(OFF_SF0, q);
        `CHK("sf0 td", 16'h0000, q)
        do_op('{2'd0, PCC_D, 1'b0}, '{1'b0, 1'b0, 6'h3f});
        `CHK("sf0 traps", 6'h3f, ctl_o.trap)
        $display("t_traps done");
    endtask

    // Interrupt status, mask, clear by one, and an unmapped address.
    task automatic t_irq();
        rd(OFF_IRQ_ST, q);
        `CHK("irq status", 16'h0003, q)
        irq_is(1'b0);
        wr(OFF_IRQ_MK, 16'h0001);
        irq_is(1'b1);
        wr(OFF_IRQ_ST, 16'h0001);
        irq_is(1'b0);
        wr(OFF_IRQ_MK, 16'h0002);
        irq_is(1'b1);
        wr(OFF_IRQ_ST, 16'h0002);
        irq_is(1'b0);
        wr(4'hf, 16'hffff);
        rd(4'hf, q);
        `CHK("unmapped", 16'h0000, q)
        rd(OFF_TRAPS, q);
        `CHK("traps kept", 16'h0000, q)
        $display("t_irq done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still reaches the report.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end

    // Main sequence: reset for twelve cycles, then each scenario.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_model();
        t_flush();
        t_traps();
        t_irq();
        close_out();
    end
endmodule // fprmc_top_tb
